// *** rtl/range_type_pkg.sv ***
// constants and carriers for the memory type range lookup
// assumes one core clock; the register port is driven by the instruction unit
package range_type_pkg;

   // memory type encodings
   localparam logic [7:0] MT_UNCACHEABLE = 8'h00;
   localparam logic [7:0] MT_WRITE_COMBINING = 8'h01;
   localparam logic [7:0] MT_WRITE_THROUGH = 8'h04;
   localparam logic [7:0] MT_WRITE_PROTECTED = 8'h05;
   localparam logic [7:0] MT_WRITEBACK = 8'h06;

   // register indices on the model register port
   localparam logic [7:0] IDX_CAPABILITIES = 8'h00;
   localparam logic [7:0] IDX_DEFAULT_TYPE = 8'h01;
   localparam logic [7:0] IDX_FIXED_FIRST = 8'h02;
   localparam logic [7:0] IDX_FIXED_LAST = 8'h0c;
   localparam logic [7:0] IDX_VAR_FIRST = 8'h10;

   // field positions
   localparam int CAP_FIXED_BIT = 8;
   localparam int CAP_WC_BIT = 10;
   localparam int CAP_SMR_BIT = 11;
   localparam int DEF_FIXED_EN_BIT = 10;
   localparam int DEF_MASTER_EN_BIT = 11;
   localparam int MASK_VALID_BIT = 11;
   localparam int PAGE_SHIFT = 12;
   localparam int FIXED_REGS = 11;

   // writable bits of the default-type register
   localparam logic [63:0] DEF_WRITABLE = 64'h0000_0000_0000_0cff;
   localparam logic [63:0] DEF_RESET = 64'h0000_0000_0000_0000;
   localparam logic [63:0] FIX_RESET = 64'h0000_0000_0000_0000;

   // fixed-range address boundaries
   localparam logic [19:0] FIX16K_START = 20'h80000;
   localparam logic [19:0] FIX4K_START = 20'hc0000;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] index;
      logic [63:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic ack;
      logic fault;
      logic [63:0] rdata;
      logic tlb_flush_all;
   } reg_rsp_t;

endpackage

// *** rtl/memory_type_range_lookup.sv ***
// memory type range unit: capability, default type, fixed and variable ranges
// assumes requests come one per cycle from core logic on clk_in
// Notes on behaviour
// - types encode uncacheable 00, combining 01, through 04, protected 05, writeback 06.
// - encodings 02, 03 and 07 upward fault when software writes them.
// - reset leaves all ranges off so every address is uncacheable.
// - up to 96 ranges: 88 fixed sub-ranges plus eight variable pairs.
// - capability register is read-only; writing it faults.
// - capability bits 7:0 give the variable range count.
// - capability bit 8 says fixed ranges exist.
// - capability bit 10 says write combining is supported.
// - capability bit 11 says system management range interface exists.
// - capability bit 9 and bits 63:12 read zero.
// - default type in bits 7:0; only 0,1,4,5,6 accepted, else fault.
// - bit 10 enables fixed ranges, which beat overlapping variable ranges.
// - with fixed ranges off, variable ranges may type the low megabyte.
// - bit 11 is master enable; clear means everything uncacheable.
// - with master enable clear the fixed enable is ignored.
// - enabled and unmatched addresses take the default type.
// - default register bits 8, 9, 63:12 reserved; nonzero write faults.
// - eleven 64-bit fixed registers, eight byte type fields each.
// - first fixed register types 0 to 7ffff in 64k pieces.
// - two registers type 80000 to bffff in 16k pieces.
// - eight registers type c0000 to fffff in 4k pieces.
// - a good write to any range register flushes all translations, global too.
// - each variable range is a base (address, type) and mask (address, valid) pair.
`timescale 1ns/1ps
module memory_type_range_lookup #(
   parameter int VAR_COUNT = 8,
   parameter int PHYS_BITS = 36,
   parameter bit HAS_FIXED = 1'b1,
   parameter bit HAS_WC = 1'b1,
   parameter bit HAS_SMR = 1'b0
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // model register port
   input wire range_type_pkg::reg_req_t req_in,
   output range_type_pkg::reg_rsp_t rsp_out,
   // type lookup
   input wire logic [PHYS_BITS-1:0] lookup_addr_in,
   output logic [7:0] lookup_type_out
);

   // 88 fixed sub-ranges leave room for at most eight variable pairs
   if (VAR_COUNT < 1 || VAR_COUNT > 8) begin : g_bad_count
      $error("variable range count must be 1 to 8");
   end
   if (PHYS_BITS < 32 || PHYS_BITS > 52) begin : g_bad_width
      $error("physical address width must be 32 to 52");
   end

   typedef struct packed {
      logic [63:0] def;
      logic [range_type_pkg::FIXED_REGS-1:0][63:0] fix;
      logic [VAR_COUNT-1:0][63:0] vbase;
      logic [VAR_COUNT-1:0][63:0] vmask;
      range_type_pkg::reg_rsp_t rsp;
   } state_t;

   state_t s_q;
   state_t s_d;

   // legal type encodings; combining only where supported
   function automatic logic type_ok(input logic [7:0] t);
      logic ok;
      ok = 1'b0;
      case (t)
         range_type_pkg::MT_UNCACHEABLE: ok = 1'b1;
         range_type_pkg::MT_WRITE_COMBINING: ok = HAS_WC;
         range_type_pkg::MT_WRITE_THROUGH: ok = 1'b1;
         range_type_pkg::MT_WRITE_PROTECTED: ok = 1'b1;
         range_type_pkg::MT_WRITEBACK: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // all eight byte fields of a fixed register legal
   function automatic logic fields_ok(input logic [63:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         ok = ok & type_ok(v[8*i +: 8]);
      end
      return ok;
   endfunction

   // mask of address bits above the page offset that exist
   function automatic logic [63:0] addr_bits();
      logic [63:0] m;
      m = '0;
      for (int i = range_type_pkg::PAGE_SHIFT; i < PHYS_BITS; i++) begin
         m[i] = 1'b1;
      end
      return m;
   endfunction

   logic [63:0] cap_value;
   always_comb begin
      cap_value = '0;
      cap_value[7:0] = 8'(VAR_COUNT);
      cap_value[range_type_pkg::CAP_FIXED_BIT] = HAS_FIXED;
      cap_value[range_type_pkg::CAP_WC_BIT] = HAS_WC;
      cap_value[range_type_pkg::CAP_SMR_BIT] = HAS_SMR;
   end

   // register access
   logic [7:0] vofs;
   logic [6:0] vsel;
   logic is_var;
   logic is_fix;
   logic [3:0] fsel;
   always_comb begin
      s_d = s_q;
      s_d.rsp = '0;
      vofs = req_in.index - range_type_pkg::IDX_VAR_FIRST;
      vsel = vofs[7:1];
      is_var = (req_in.index >= range_type_pkg::IDX_VAR_FIRST) &&
         (32'(vsel) < VAR_COUNT);
      is_fix = HAS_FIXED && (req_in.index >= range_type_pkg::IDX_FIXED_FIRST) &&
         (req_in.index <= range_type_pkg::IDX_FIXED_LAST);
      fsel = 4'(req_in.index - range_type_pkg::IDX_FIXED_FIRST);
      if (req_in.valid) begin
         s_d.rsp.ack = 1'b1;
         if (!req_in.write) begin
            if (req_in.index == range_type_pkg::IDX_CAPABILITIES) begin
               s_d.rsp.rdata = cap_value;
            end else if (req_in.index == range_type_pkg::IDX_DEFAULT_TYPE) begin
               s_d.rsp.rdata = s_q.def;
            end else if (is_fix) begin
               s_d.rsp.rdata = s_q.fix[fsel];
            end else if (is_var) begin
               s_d.rsp.rdata = vofs[0] ? s_q.vmask[vsel[2:0]] : s_q.vbase[vsel[2:0]];
            end else begin
               s_d.rsp.fault = 1'b1;
            end
         end else if (req_in.index == range_type_pkg::IDX_CAPABILITIES) begin
            s_d.rsp.fault = 1'b1;
         end else if (req_in.index == range_type_pkg::IDX_DEFAULT_TYPE) begin
            // reserved bits and bad type refuse the whole write
            if (|(req_in.wdata & ~range_type_pkg::DEF_WRITABLE) ||
                  !type_ok(req_in.wdata[7:0])) begin
               s_d.rsp.fault = 1'b1;
            end else begin
               s_d.def = req_in.wdata;
               s_d.rsp.tlb_flush_all = 1'b1;
            end
         end else if (is_fix) begin
            if (!fields_ok(req_in.wdata)) begin
               s_d.rsp.fault = 1'b1;
            end else begin
               s_d.fix[fsel] = req_in.wdata;
               s_d.rsp.tlb_flush_all = 1'b1;
            end
         end else if (is_var) begin
            if (vofs[0]) begin
               if (|(req_in.wdata & ~(addr_bits() | 64'h0000_0000_0000_0800))) begin
                  s_d.rsp.fault = 1'b1;
               end else begin
                  s_d.vmask[vsel[2:0]] = req_in.wdata;
                  s_d.rsp.tlb_flush_all = 1'b1;
               end
            end else if (!type_ok(req_in.wdata[7:0]) ||
                  |(req_in.wdata & ~(addr_bits() | 64'h0000_0000_0000_00ff))) begin
               s_d.rsp.fault = 1'b1;
            end else begin
               s_d.vbase[vsel[2:0]] = req_in.wdata;
               s_d.rsp.tlb_flush_all = 1'b1;
            end
         end else begin
            s_d.rsp.fault = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q.def <= range_type_pkg::DEF_RESET;
         for (int i = 0; i < range_type_pkg::FIXED_REGS; i++) begin
            s_q.fix[i] <= range_type_pkg::FIX_RESET;
         end
         s_q.vbase <= '0;
         s_q.vmask <= '0;
         s_q.rsp <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp_out = s_q.rsp;

   // type lookup, purely combinational so the requester sees it same cycle
   logic [63:0] a64;
   logic low_mb;
   logic [3:0] freg;
   logic [2:0] ffld;
   logic var_hit;
   logic var_uc;
   logic [7:0] var_type;
   logic [63:0] am;
   always_comb begin
      a64 = 64'(lookup_addr_in);
      low_mb = (a64[63:20] == '0);
      if (a64[19:0] < range_type_pkg::FIX16K_START) begin
         freg = 4'h0;
         ffld = a64[18:16];
      end else if (a64[19:0] < range_type_pkg::FIX4K_START) begin
         freg = {3'b000, a64[17]} + 4'h1;
         ffld = a64[16:14];
      end else begin
         freg = {1'b0, a64[17:15]} + 4'h3;
         ffld = a64[14:12];
      end
      var_hit = 1'b0;
      var_uc = 1'b0;
      var_type = range_type_pkg::MT_UNCACHEABLE;
      am = addr_bits();
      // first matching pair wins, but any uncacheable match overrides
      for (int i = VAR_COUNT - 1; i >= 0; i--) begin
         if (s_q.vmask[i][range_type_pkg::MASK_VALID_BIT] &&
               ((a64 & s_q.vmask[i] & am) == (s_q.vbase[i] & s_q.vmask[i] & am))) begin
            var_hit = 1'b1;
            var_type = s_q.vbase[i][7:0];
            var_uc = var_uc | (s_q.vbase[i][7:0] == range_type_pkg::MT_UNCACHEABLE);
         end
      end
      if (!s_q.def[range_type_pkg::DEF_MASTER_EN_BIT]) begin
         lookup_type_out = range_type_pkg::MT_UNCACHEABLE;
      end else if (HAS_FIXED && s_q.def[range_type_pkg::DEF_FIXED_EN_BIT] && low_mb) begin
         lookup_type_out = s_q.fix[freg][8*ffld +: 8];
      end else if (var_hit) begin
         lookup_type_out = var_uc ? range_type_pkg::MT_UNCACHEABLE : var_type;
      end else begin
         lookup_type_out = s_q.def[7:0];
      end
   end

endmodule

// *** testbench/range_lookup_sva.sv ***
// port checker for the memory type range lookup
// assumes binding onto the top module with its parameters
`timescale 1ns/1ps
module range_lookup_sva #(
   parameter int VAR_COUNT = 8,
   parameter int PHYS_BITS = 36,
   parameter bit HAS_FIXED = 1'b1,
   parameter bit HAS_WC = 1'b1,
   parameter bit HAS_SMR = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire range_type_pkg::reg_req_t req_in,
   input wire range_type_pkg::reg_rsp_t rsp_out,
   input wire logic [PHYS_BITS-1:0] lookup_addr_in,
   input wire logic [7:0] lookup_type_out
);
   localparam logic [63:0] CAP = {52'h0, HAS_SMR, HAS_WC, 1'b0, HAS_FIXED, 8'(VAR_COUNT)};
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic rd = req_in.valid && !req_in.write;
   wire logic wr = req_in.valid && req_in.write;
   wire logic dw = wr && req_in.index == range_type_pkg::IDX_DEFAULT_TYPE;
   wire logic [7:0] t = req_in.wdata[7:0];
   wire logic bad_t = !(t inside {8'h00, 8'h04, 8'h05, 8'h06} || (t == 8'h01 && HAS_WC));
   property p_ack; rsp_out.ack == $past(req_in.valid); endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
   property p_cap_ro; wr && req_in.index == 8'h00 |=> rsp_out.fault; endproperty
   a_cap_ro: assert property (p_cap_ro) else $error("capability write accepted");
   property p_cap; rd && req_in.index == 8'h00 |=> rsp_out.rdata == CAP; endproperty
   a_cap: assert property (p_cap) else $error("capability value wrong");
   property p_rsvd; dw && (req_in.wdata[9:8] != 0 || req_in.wdata[63:12] != 0) |=> rsp_out.fault;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved default bits accepted");
   property p_dtype; dw && bad_t |=> rsp_out.fault && !rsp_out.tlb_flush_all; endproperty
   a_dtype: assert property (p_dtype) else $error("illegal default type accepted");
   property p_flush; wr |=> rsp_out.tlb_flush_all != rsp_out.fault; endproperty
   a_flush: assert property (p_flush) else $error("write flush wrong");
   property p_rst; $rose(rst_b_in) |-> lookup_type_out == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("type not uncacheable after reset");
   property p_legal; lookup_type_out inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06}; endproperty
   a_legal: assert property (p_legal) else $error("lookup type encoding illegal");
   c_flush: cover property (rsp_out.tlb_flush_all);
   c_fault: cover property (rsp_out.fault);
   c_wb: cover property (lookup_type_out == range_type_pkg::MT_WRITEBACK);
endmodule
bind memory_type_range_lookup range_lookup_sva #(.VAR_COUNT(VAR_COUNT), .PHYS_BITS(PHYS_BITS),
   .HAS_FIXED(HAS_FIXED), .HAS_WC(HAS_WC), .HAS_SMR(HAS_SMR)) sva_u (.clk_in(clk_in),
   .rst_b_in(rst_b_in), .req_in(req_in), .rsp_out(rsp_out), .lookup_addr_in(lookup_addr_in),
   .lookup_type_out(lookup_type_out));

// *** testbench/memory_type_range_lookup_tb.sv ***
// self-checking bench for the memory type range lookup
// assumes default parameters and the package index map
`timescale 1ns/1ps
module memory_type_range_lookup_tb;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   range_type_pkg::reg_req_t req_in = '0;
   range_type_pkg::reg_rsp_t rsp_out;
   logic [35:0] lookup_addr_in = '0;
   logic [7:0] lookup_type_out;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [63:0] def_v = '0;
   logic [63:0] fix_v [11];
   logic var_on = 1'b0;
   logic [7:0] legal [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
   logic [63:0] w;
   logic [63:0] v;
   logic [63:0] modes [5] = '{64'h406, 64'h806, 64'hc06, 64'hc01, 64'h0};
   logic [35:0] edges [10] = '{0, 'h7ffff, 'h80000, 'h9ffff, 'ha0000, 'hbffff, 'hc0000,
      'hf8000, 'hfffff, 'h100000};
   always #4 clk_in = ~clk_in;
   memory_type_range_lookup dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(req_in),
      .rsp_out(rsp_out), .lookup_addr_in(lookup_addr_in), .lookup_type_out(lookup_type_out));
   task automatic finish_test();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk_val(input string n, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [7:0] exp_type(input logic [35:0] ad);
      int r;
      int f;
      if (!def_v[11]) return 8'h00;
      if (ad < 36'h100000 && def_v[10]) begin
         r = ad < 36'h80000 ? 0 : ad < 36'hc0000 ? 1 + ad[17] : 3 + ad[17:15];
         f = ad < 36'h80000 ? ad[18:16] : ad < 36'hc0000 ? ad[16:14] : ad[14:12];
         return fix_v[r][f*8 +: 8];
      end
      if (ad < 36'h100000 && var_on) return 8'h04;
      return def_v[7:0];
   endfunction
   // combinational output, so sampled a step after the address settles
   task automatic chk_type(input logic [35:0] ad);
      logic [7:0] e;
      e = exp_type(ad);
      @(posedge clk_in);
      #1 lookup_addr_in = ad;
      #1 cmp_count++;
      if (lookup_type_out !== e) begin
         error_cnt++;
         $display("unexpected lookup type at %h expected %h seen %h", ad, e, lookup_type_out);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] ix, input logic [63:0] wd, input logic f);
      @(posedge clk_in);
      #1 req_in = '{1'b1, wr, ix, wd};
      @(posedge clk_in);
      #1 req_in = '0;
      chk_val("ack", 64'h1, {63'h0, rsp_out.ack});
      chk_val("fault", {63'h0, f}, {63'h0, rsp_out.fault});
      chk_val("flush", {63'h0, wr & ~f}, {63'h0, rsp_out.tlb_flush_all});
      w = rsp_out.rdata;
   endtask
   task automatic rd(input logic [7:0] ix, input logic [63:0] e);
      acc(1'b0, ix, 64'h0, 1'b0);
      chk_val("rdata", e, w);
   endtask
   initial begin
      #700000 error_cnt++;
      finish_test();
   end
   initial begin
      void'($urandom(41693));
      foreach (fix_v[i]) fix_v[i] = '0;
      repeat (20) @(posedge clk_in);
      #1 rst_b_in = 1'b1;
      repeat (4) chk_type(36'($urandom));
      rd(8'h00, 64'h508);
      acc(1'b1, 8'h00, 64'hffff, 1'b1);
      rd(8'h00, 64'h508);
      acc(1'b0, 8'h0d, 64'h0, 1'b1);
      foreach (legal[k]) acc(1'b1, 8'h01, {56'h0, legal[k] + 8'h07}, 1'b1);
      acc(1'b1, 8'h01, 64'h2, 1'b1);
      acc(1'b1, 8'h01, 64'h3, 1'b1);
      acc(1'b1, 8'h01, {56'h0, 8'($urandom_range(255, 7))}, 1'b1);
      acc(1'b1, 8'h01, 64'h906, 1'b1);
      acc(1'b1, 8'h01, 64'h1006, 1'b1);
      acc(1'b1, 8'h01, {32'($urandom) | 32'h1, 32'h6}, 1'b1);
      for (int i = 0; i < 11; i++) begin
         for (int b = 0; b < 8; b++) v[b*8 +: 8] = legal[$urandom_range(4)];
         fix_v[i] = v;
         acc(1'b1, 8'(i + 2), v, 1'b0);
      end
      foreach (fix_v[i]) rd(8'(i + 2), fix_v[i]);
      acc(1'b1, 8'h02, 64'h0300, 1'b1);
      rd(8'h02, fix_v[0]);
      acc(1'b1, 8'h10, 64'h4, 1'b0);
      acc(1'b1, 8'h11, 64'hf_fff0_0800, 1'b0);
      var_on = 1'b1;
      foreach (modes[m]) begin
         def_v = modes[m];
         acc(1'b1, 8'h01, def_v, 1'b0);
         rd(8'h01, def_v);
         foreach (edges[k]) chk_type(edges[k]);
         repeat (30) chk_type(36'($urandom_range(32'h10ffff)));
      end
      finish_test();
   end
endmodule
